// file: rtl/svc_engine.sv
// Host service interpreter: feature setup, internal registers, frame send
`timescale 1ns/100ps
module svc_engine #(
  parameter int BIT_CYC     = svc_pkg::BIT_CYC,
  parameter int SILENCE_CYC = svc_pkg::SILENCE_CYC
) (
  // Clock and reset
  input  logic                                core_clk,
  input  logic                                nrst,
  // Bytes from host
  input  logic                                host_rx_valid,
  input  logic [7:0]                          host_rx_data,
  output logic                                host_rx_ready,
  // Bytes to host
  output logic                                host_tx_valid,
  output logic [7:0]                          host_tx_data,
  input  logic                                host_tx_ready,
  // Link and device state
  input  logic                                nine_bit_mode,
  input  logic                                bus_sync_done,
  input  logic                                bus_idle,
  input  logic                                busy_mode,
  input  logic                                auto_ack_active_flag,
  input  logic                                repeat_enable,
  output svc_pkg::mode_t                      dev_mode,
  // Feature flags
  output logic                                auto_poll_active_flag,
  output logic                                crc_active,
  output logic                                marker_active,
  // Bus transmitter
  output logic                                bus_tx_valid,
  output logic [7:0]                          bus_tx_data,
  input  logic                                bus_tx_ready,
  input  logic                                bus_res_valid,
  input  logic [1:0]                          bus_res,
  input  logic                                corrupt_byte_flag,
  input  logic                                sum_len_error_flag,
  input  logic                                bus_timing_error_flag,
  // Internal registers
  output logic [svc_pkg::REG_N-1:0][7:0]      dev_regs
);
  typedef enum {S_IDLE, S_ARG, S_CFG, S_RD, S_READY, S_SUM_A, S_SUM_B, S_CHK, S_BAD,
                S_LD, S_SEND, S_ECHO, S_ECHO2, S_RES, S_GAP, S_CRC_H, S_CRC_L,
                S_FEND, S_SIL, S_FRES, S_CONF} state_t;
  typedef enum {K_REG, K_BUF, K_SUM} kind_t;
  localparam int IW = svc_pkg::IDX_W;

  state_t                 st_r, st_nxt, post_st, crc_post_st;
  kind_t                  kind_r;
  svc_pkg::mode_t         mode_r;
  logic                   rx_ready_r, ack_pend_r, push_r, emit, frame_ok_r, ack_r;
  logic [7:0]             push_d_r, emit_d, buf_q_r, acc_r, sum_rx_r, gap_r, idle_bits_r;
  logic [2:0]             ofs_r, cfg_pend_r, busy_cnt_r, nack_cnt_r;
  logic                   fp_r, fc_r, fm_r;
  logic [svc_pkg::REG_AW-1:0] reg_a_r;
  logic [7:0]             regs_r [svc_pkg::REG_N];
  logic [7:0]             tx_buf [svc_pkg::BUF_DEPTH];
  logic [IW-1:0]          idx_r, wr_idx_r, len_r;
  logic [15:0]            crc_r;
  logic [svc_pkg::BIT_W-1:0] bit_cnt_r;
  logic [svc_pkg::SIL_W-1:0] sil_r;
  logic                   fifo_in_ready;

  // Decode of the host byte
  wire take     = host_rx_valid & rx_ready_r;
  wire [7:0] d  = host_rx_data;
  wire op_exit  = d == svc_pkg::OP_EXIT_STOP;
  wire op_ofs   = (d & svc_pkg::OP_MASK_5) == svc_pkg::OP_OFFSET;
  wire op_cfg   = (d & svc_pkg::OP_MASK_5) == svc_pkg::OP_CONFIG;
  wire op_rwr   = (d & svc_pkg::OP_MASK_5) == svc_pkg::OP_REG_WR;
  wire op_rrd   = (d & svc_pkg::OP_MASK_5) == svc_pkg::OP_REG_RD;
  wire op_begin = d == svc_pkg::OP_BEGIN;
  wire op_cont  = ((d & svc_pkg::OP_MASK_2) == svc_pkg::OP_CONT) & (d[5:0] != 6'h00);
  wire op_end   = (d & svc_pkg::OP_MASK_2) == svc_pkg::OP_FINISH;
  wire idle_tk  = (st_r == S_IDLE) & take;

  // Emission toward the FIFO; a held byte waits for room
  wire em_ok    = ~push_r | fifo_in_ready;
  wire cfg_ok   = bus_idle | (mode_r != svc_pkg::M_NORMAL);
  wire [7:0] cfg_ind = {busy_mode, auto_ack_active_flag, fp_r | cfg_pend_r[svc_pkg::CFG_P_BIT],
                        fc_r | cfg_pend_r[svc_pkg::CFG_C_BIT],
                        fm_r | cfg_pend_r[svc_pkg::CFG_M_BIT], svc_pkg::CFG_IND_LOW};
  wire [7:0] fres_d  = {corrupt_byte_flag, 1'b0, sum_len_error_flag, 1'b0,
                        bus_timing_error_flag, svc_pkg::FRES_LOW};
  wire [7:0] conf_d  = {ack_r, svc_pkg::CONF_LOW};

  // Frame walk
  wire last_sum = ({1'b0, idx_r} + 10'h001) >= {1'b0, len_r};
  wire at_len   = idx_r == len_r;
  wire sum_ok   = ~acc_r == sum_rx_r;
  wire dup      = fm_r & (buf_q_r == svc_pkg::IND_FRAME_END);
  wire adv      = em_ok & (((st_r == S_ECHO) & ~dup) | (st_r == S_ECHO2));
  wire ok_res   = bus_res == svc_pkg::RES_ACK;
  wire rt_busy  = repeat_enable & (bus_res == svc_pkg::RES_BUSY) & (busy_cnt_r != 3'h0);
  wire rt_other = repeat_enable & ~ok_res & (bus_res != svc_pkg::RES_BUSY)
                  & (nack_cnt_r != 3'h0);
  wire bit_tick = bit_cnt_r == svc_pkg::BIT_W'(BIT_CYC - 1);
  wire idle_clr = (st_r != S_GAP) | ~bus_idle;
  wire gap_done = idle_bits_r >= gap_r;
  wire silent   = ~host_tx_valid & ~push_r;
  wire sil_done = sil_r == svc_pkg::SIL_W'(SILENCE_CYC);
  wire buf_we   = ((st_r == S_ARG) & take & (kind_r == K_BUF)) | ((st_r == S_CHK) & sum_ok);
  wire [IW-1:0] buf_wa = (st_r == S_CHK) ? len_r : wr_idx_r;
  wire [7:0] buf_wd    = (st_r == S_CHK) ? sum_rx_r : d;

  assign crc_post_st = fm_r ? S_FEND : S_SIL;
  assign post_st     = fc_r ? S_CRC_H : crc_post_st;
  assign host_rx_ready         = rx_ready_r;
  assign dev_mode              = mode_r;
  assign auto_poll_active_flag = fp_r;
  assign crc_active            = fc_r;
  assign marker_active         = fm_r;
  for (genvar g = 0; g < svc_pkg::REG_N; g++) begin : g_regs
    assign dev_regs[g] = regs_r[g];
  end

  always_comb begin
    st_nxt = st_r;
    emit   = 1'b0;
    emit_d = 8'h00;
    unique case (st_r)
      S_IDLE: begin
        if (take) begin
          if (op_cfg) begin
            st_nxt = S_CFG;
          end else if (op_rrd) begin
            st_nxt = S_RD;
          end else if (op_rwr | op_begin | op_cont | op_end) begin
            st_nxt = S_ARG;
          end
        end else if (ack_pend_r) begin
          st_nxt = S_READY;
        end
      end
      S_ARG:   if (take) st_nxt = (kind_r == K_SUM) ? S_SUM_A : S_IDLE;
      S_CFG:   if (cfg_ok & em_ok) begin
        emit   = 1'b1;
        emit_d = cfg_ind;
        st_nxt = S_IDLE;
      end
      S_RD:    if (em_ok) begin
        emit   = 1'b1;
        emit_d = regs_r[reg_a_r];
        st_nxt = S_IDLE;
      end
      S_READY: if (em_ok) begin
        emit   = 1'b1;
        emit_d = svc_pkg::IND_READY;
        st_nxt = S_IDLE;
      end
      S_SUM_A: st_nxt = S_SUM_B;
      S_SUM_B: st_nxt = last_sum ? S_CHK : S_SUM_A;
      S_CHK:   st_nxt = sum_ok ? S_LD : S_BAD;
      S_BAD:   if (em_ok) begin
        emit   = 1'b1;
        emit_d = svc_pkg::IND_STATE_RE;
        st_nxt = S_IDLE;
      end
      S_LD:    st_nxt = S_SEND;
      S_SEND:  if (bus_tx_valid & bus_tx_ready) st_nxt = S_ECHO;
      S_ECHO:  if (em_ok) begin
        emit   = 1'b1;
        emit_d = buf_q_r;
        st_nxt = dup ? S_ECHO2 : (at_len ? S_RES : S_LD);
      end
      S_ECHO2: if (em_ok) begin
        emit   = 1'b1;
        emit_d = buf_q_r;
        st_nxt = at_len ? S_RES : S_LD;
      end
      S_RES:   if (bus_res_valid) st_nxt = (rt_busy | rt_other) ? S_GAP : post_st;
      S_GAP:   if (gap_done) st_nxt = S_LD;
      S_CRC_H: if (em_ok) begin
        emit   = 1'b1;
        emit_d = crc_r[15:8];
        st_nxt = S_CRC_L;
      end
      S_CRC_L: if (em_ok) begin
        emit   = 1'b1;
        emit_d = crc_r[7:0];
        st_nxt = crc_post_st;
      end
      S_FEND:  if (em_ok) begin
        emit   = 1'b1;
        emit_d = svc_pkg::IND_FRAME_END;
        st_nxt = S_FRES;
      end
      S_SIL:   if (sil_done) st_nxt = nine_bit_mode ? S_CONF : S_FRES;
      S_FRES:  if (em_ok) begin
        emit   = 1'b1;
        emit_d = fres_d;
        st_nxt = S_CONF;
      end
      S_CONF:  if (em_ok) begin
        emit   = 1'b1;
        emit_d = conf_d;
        st_nxt = S_IDLE;
      end
    endcase
  end

  // Buffer has no reset; out-of-range indexes are dropped
  always_ff @(posedge core_clk) begin
    if (buf_we && (buf_wa < IW'(svc_pkg::BUF_DEPTH))) begin
      tx_buf[buf_wa] <= buf_wd;
    end
    buf_q_r <= (idx_r < IW'(svc_pkg::BUF_DEPTH)) ? tx_buf[idx_r] : 8'h00;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_r       <= S_IDLE;
      rx_ready_r <= 1'b0;
      push_r     <= 1'b0;
      push_d_r   <= 8'h00;
      mode_r     <= svc_pkg::M_STOP;
      ack_pend_r <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      rx_ready_r <= (st_nxt == S_IDLE) | (st_nxt == S_ARG);
      push_r     <= emit | (push_r & ~fifo_in_ready);
      push_d_r   <= emit ? emit_d : push_d_r;
      if (idle_tk & op_exit & (mode_r == svc_pkg::M_STOP)) begin
        mode_r <= svc_pkg::M_SYNC;
      end else if ((mode_r == svc_pkg::M_SYNC) & bus_sync_done) begin
        mode_r <= svc_pkg::M_NORMAL;
      end
      // Set wins over the clear
      ack_pend_r <= ((mode_r == svc_pkg::M_SYNC) & bus_sync_done)
                    | (ack_pend_r & ~((st_r == S_READY) & em_ok));
    end
  end

  // Request fields, features and registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      kind_r     <= K_REG;
      ofs_r      <= 3'h0;
      cfg_pend_r <= 3'h0;
      reg_a_r    <= '0;
      wr_idx_r   <= '0;
      len_r      <= '0;
      sum_rx_r   <= 8'h00;
      {fp_r, fc_r, fm_r} <= 3'h0;
      for (int i = 0; i < svc_pkg::REG_N; i++) begin
        regs_r[i] <= (svc_pkg::REG_AW'(i) == svc_pkg::WDOG_ADDR) ? svc_pkg::WDOG_RST : 8'h00;
      end
    end else begin
      if (idle_tk) begin
        if (op_ofs) ofs_r <= d[2:0];
        if (op_begin) ofs_r <= 3'h0;
        if (op_cfg) cfg_pend_r <= d[2:0];
        if (op_rwr | op_rrd) reg_a_r <= d[svc_pkg::REG_AW-1:0];
        if (op_begin) wr_idx_r <= '0;
        if (op_cont) wr_idx_r <= {ofs_r, d[5:0]};
        if (op_end) len_r <= {ofs_r, d[5:0]};
        kind_r <= op_rwr ? K_REG : (op_end ? K_SUM : K_BUF);
      end
      if ((st_r == S_ARG) & take & (kind_r == K_REG)) regs_r[reg_a_r] <= d;
      if ((st_r == S_ARG) & take & (kind_r == K_SUM)) sum_rx_r <= d;
      if ((st_r == S_CFG) & cfg_ok & em_ok) begin
        // Bits only ever set; a zero leaves the feature as it was
        fp_r <= fp_r | cfg_pend_r[svc_pkg::CFG_P_BIT];
        fc_r <= fc_r | cfg_pend_r[svc_pkg::CFG_C_BIT];
        fm_r <= fm_r | cfg_pend_r[svc_pkg::CFG_M_BIT];
      end
    end
  end

  // Checksum walk, bus transmit and retries
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      idx_r        <= '0;
      acc_r        <= 8'h00;
      crc_r        <= svc_pkg::CRC_INIT;
      bus_tx_valid <= 1'b0;
      bus_tx_data  <= 8'h00;
      busy_cnt_r   <= svc_pkg::RETRY_RST;
      nack_cnt_r   <= svc_pkg::RETRY_RST;
      gap_r        <= svc_pkg::OTHER_GAP_BITS;
      ack_r        <= 1'b0;
      frame_ok_r   <= 1'b0;
    end else begin
      if ((st_r == S_ARG) & take & (kind_r == K_SUM)) begin
        idx_r <= '0;
        acc_r <= 8'h00;
      end
      if (st_r == S_SUM_B) begin
        acc_r <= acc_r ^ buf_q_r;
        if (!last_sum) idx_r <= idx_r + 1'b1;
      end
      if ((st_r == S_CHK) | ((st_r == S_GAP) & gap_done)) begin
        idx_r <= '0;
        crc_r <= svc_pkg::CRC_INIT;
      end
      if (st_r == S_CHK) begin
        busy_cnt_r <= svc_pkg::RETRY_RST;
        nack_cnt_r <= svc_pkg::RETRY_RST;
      end
      frame_ok_r <= (st_r == S_CHK) ? sum_ok : (frame_ok_r & (st_r != S_IDLE));
      if ((st_r == S_ECHO) & em_ok) crc_r <= svc_pkg::crc_step(crc_r, buf_q_r);
      if (adv & ~at_len) idx_r <= idx_r + 1'b1;
      bus_tx_valid <= (st_r == S_SEND) & (st_nxt == S_SEND);
      bus_tx_data  <= buf_q_r;
      if ((st_r == S_RES) & bus_res_valid) begin
        ack_r <= ok_res;
        if (rt_busy) begin
          busy_cnt_r <= busy_cnt_r - 3'h1;
          gap_r      <= svc_pkg::BUSY_GAP_BITS;
        end else if (rt_other) begin
          nack_cnt_r <= nack_cnt_r - 3'h1;
          gap_r      <= svc_pkg::OTHER_GAP_BITS;
        end
      end
    end
  end

  // Bit-time enable and idle/silence counters
  always_ff @(posedge core_clk) begin
    if (!nrst || idle_clr) begin
      bit_cnt_r   <= '0;
      idle_bits_r <= 8'h00;
    end else begin
      bit_cnt_r <= bit_tick ? '0 : bit_cnt_r + 1'b1;
      if (bit_tick && idle_bits_r != 8'hff) idle_bits_r <= idle_bits_r + 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst || st_r != S_SIL || !silent) begin
      sil_r <= '0;
    end else if (!sil_done) begin
      sil_r <= sil_r + 1'b1;
    end
  end

  svc_fifo #(.W(svc_pkg::FIFO_W), .D(svc_pkg::FIFO_D)) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (push_r),
    .in_data   (push_d_r),
    .in_ready  (fifo_in_ready),
    .out_valid (host_tx_valid),
    .out_data  (host_tx_data),
    .out_ready (host_tx_ready)
  );

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_exit_ack: assert property ((st_r == S_READY) & em_ok |=> push_r & (push_d_r == svc_pkg::IND_READY))
    else $error("exit-stop acknowledge not emitted");
  a_cfg_gate: assert property ((st_r == S_CFG) & ~cfg_ok |=> $stable({fp_r, fc_r, fm_r}))
    else $error("features changed while bus busy in normal");
  a_feat_keep: assert property ($past(fc_r) |-> fc_r)
    else $error("feature deactivated without reset");
  a_ofs_clear: assert property (idle_tk & op_begin |=> (ofs_r == 3'h0) & (st_r == S_ARG))
    else $error("offset not cleared on begin");
  a_reg_read: assert property ((st_r == S_RD) & em_ok |=> push_d_r == $past(regs_r[reg_a_r]))
    else $error("register read returned wrong byte");
  a_send_gate: assert property (bus_tx_valid |-> frame_ok_r)
    else $error("bus send without verified checksum");
  a_sum_bad: assert property ((st_r == S_CHK) & ~sum_ok |=> (st_r == S_BAD) ##1 ~bus_tx_valid)
    else $error("bad checksum not reported");
  a_echo_dup: assert property ((st_r == S_ECHO) & em_ok & dup |=> st_r == S_ECHO2)
    else $error("marker octet not echoed twice");
  a_one_try: assert property ((st_r == S_RES) & bus_res_valid & ~repeat_enable |=> st_r != S_GAP)
    else $error("retry without repetition enabled");
  a_busy_gap: assert property ((st_r == S_RES) & bus_res_valid & rt_busy
                               |=> (gap_r == svc_pkg::BUSY_GAP_BITS) & (st_r == S_GAP))
    else $error("busy retry gap wrong");
  a_wr_store: assert property ((st_r == S_ARG) & take & (kind_r == K_REG)
                               |=> regs_r[$past(reg_a_r)] == $past(host_rx_data))
    else $error("register write not stored");

  c_frame_done: cover property ((st_r == S_CONF) & em_ok & ack_r);
  c_retry:      cover property ((st_r == S_GAP) ##1 (st_r == S_LD));
  c_bad_sum:    cover property (st_r == S_BAD);
endmodule

// file: rtl/svc_fifo.sv
// Byte FIFO with registered output toward the host link
`timescale 1ns/100ps
module svc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input  logic         core_clk,
  input  logic         nrst,
  // Fill side
  input  logic         in_valid,
  input  logic [W-1:0] in_data,
  output logic         in_ready,
  // Drain side
  output logic         out_valid,
  output logic [W-1:0] out_data,
  input  logic         out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic          out_valid_r;
  logic [W-1:0]  out_data_r;
  wire           push = in_valid & in_ready;
  wire           pop  = (cnt_r != '0) & (~out_valid_r | out_ready);

  assign in_ready  = cnt_r < CW'(D);
  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wp_r        <= '0;
      rp_r        <= '0;
      cnt_r       <= '0;
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r       <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
        out_data_r <= mem[rp_r];
      end
      if (pop) begin
        out_valid_r <= 1'b1;
      end else if (out_ready) begin
        out_valid_r <= 1'b0;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// file: shared/svc_pkg.sv
// Constants, encodings and helpers for the host service interpreter
package svc_pkg;
  // Timing
  localparam int CLK_HZ      = 125_000_000;
  localparam int CLK_NS      = 8;
  localparam int BUS_BAUD    = 9600;
  localparam int SILENCE_NS  = 2_600_000;
  localparam int SILENCE_CYC = (SILENCE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIT_CYC     = (CLK_HZ + BUS_BAUD - 1) / BUS_BAUD;
  localparam int BIT_W       = 14;
  localparam int SIL_W       = 19;

  // Repetition
  localparam logic [2:0] RETRY_RST      = 3'h3;
  localparam logic [7:0] BUSY_GAP_BITS  = 8'h96;
  localparam logic [7:0] OTHER_GAP_BITS = 8'h32;

  // Transmit buffer and host FIFO
  localparam int IDX_W     = 9;
  localparam int BUF_DEPTH = 263;
  localparam int FIFO_W    = 8;
  localparam int FIFO_D    = 8;

  // Internal registers
  localparam int         REG_N     = 8;
  localparam int         REG_AW    = 3;
  localparam logic [2:0] WDOG_ADDR = 3'h0;
  localparam logic [7:0] WDOG_RST  = 8'h0f;

  // Service opcodes, one table
  localparam logic [7:0] OP_MASK_5    = 8'hf8;
  localparam logic [7:0] OP_MASK_2    = 8'hc0;
  localparam logic [7:0] OP_EXIT_STOP = 8'h04;
  localparam logic [7:0] OP_OFFSET    = 8'h08;
  localparam logic [7:0] OP_CONFIG    = 8'h18;
  localparam logic [7:0] OP_REG_WR    = 8'h28;
  localparam logic [7:0] OP_REG_RD    = 8'h38;
  localparam logic [7:0] OP_BEGIN     = 8'h80;
  localparam logic [7:0] OP_CONT      = 8'h80;
  localparam logic [7:0] OP_FINISH    = 8'h40;
  localparam int         CFG_P_BIT    = 0;
  localparam int         CFG_C_BIT    = 1;
  localparam int         CFG_M_BIT    = 2;

  // Indications to the host
  localparam logic [7:0] IND_READY     = 8'h07;
  localparam logic [7:0] IND_STATE_RE  = 8'h87;
  localparam logic [7:0] IND_FRAME_END = 8'hcb;
  localparam logic [2:0] CFG_IND_LOW   = 3'h1;
  localparam logic [2:0] FRES_LOW      = 3'h3;
  localparam logic [6:0] CONF_LOW      = 7'h0b;

  // Bus acknowledge results
  localparam logic [1:0] RES_ACK  = 2'h0;
  localparam logic [1:0] RES_NACK = 2'h1;
  localparam logic [1:0] RES_BUSY = 2'h2;
  localparam logic [1:0] RES_NONE = 2'h3;

  // CRC
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  typedef enum logic [1:0] {M_STOP, M_SYNC, M_NORMAL} mode_t;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction
endpackage

// file: test/bus_phy_model.sv
// Bus physical layer stand-in: slow byte take, one result per frame
`timescale 1ns/100ps
module bus_phy_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Byte stream
  input  wire logic       bus_tx_valid,
  input  wire logic [7:0] bus_tx_data,
  output logic            bus_tx_ready,
  // Result
  input  wire logic [1:0] res_code,
  output logic            bus_res_valid,
  output logic [1:0]      bus_res
);
  logic [3:0] quiet_r;
  logic       sent_r;
  // Result lines carry noise outside the pulse
  assign bus_res = bus_res_valid ? res_code : ~res_code;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bus_tx_ready  <= 1'b0;
      quiet_r       <= 4'h0;
      sent_r        <= 1'b0;
      bus_res_valid <= 1'b0;
    end else begin
      bus_tx_ready  <= bus_tx_valid & ~bus_tx_ready;
      bus_res_valid <= sent_r & (quiet_r == 4'hf);
      if (bus_tx_valid & bus_tx_ready) begin
        sent_r  <= 1'b1;
        quiet_r <= 4'h0;
      end else if (sent_r) begin
        quiet_r <= quiet_r + 4'h1;
        if (quiet_r == 4'hf) sent_r <= 1'b0;
      end
    end
  end
endmodule

// file: test/testbench.sv
// Self-checking bench for the host service interpreter
`timescale 1ns/100ps
module testbench;
  logic core_clk, nrst, rx_v, rx_r, tx_v, tx_rdy, sync_d, busy, aa, brv, btv, btr, re;
  logic [7:0] rx_d, tx_d, bt_d;
  logic [1:0] br;
  logic ap, crc, mk;
  logic ce, te, idle;
  svc_pkg::mode_t mode;
  logic [svc_pkg::REG_N-1:0][7:0] regs;
  int n_mismatch = 0;
  int check_count = 0;
  svc_engine #(.BIT_CYC(4), .SILENCE_CYC(20)) uut (.core_clk(core_clk), .nrst(nrst),
    .host_rx_valid(rx_v), .host_rx_data(rx_d), .host_rx_ready(rx_r), .host_tx_valid(tx_v),
    .host_tx_data(tx_d), .host_tx_ready(tx_rdy), .nine_bit_mode(1'b0), .bus_sync_done(sync_d),
    .bus_idle(idle), .busy_mode(busy), .auto_ack_active_flag(aa), .repeat_enable(1'b0),
    .dev_mode(mode), .auto_poll_active_flag(ap), .crc_active(crc), .marker_active(mk),
    .bus_tx_valid(btv), .bus_tx_data(bt_d), .bus_tx_ready(btr), .bus_res_valid(brv),
    .bus_res(br), .corrupt_byte_flag(re), .sum_len_error_flag(ce),
    .bus_timing_error_flag(te), .dev_regs(regs));
  bus_phy_model phy (.core_clk(core_clk), .nrst(nrst), .bus_tx_valid(btv),
    .bus_tx_data(bt_d), .bus_tx_ready(btr), .res_code(svc_pkg::RES_NACK),
    .bus_res_valid(brv), .bus_res(br));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] b);
    int i;
    @(posedge core_clk);
    rx_v <= 1'b1;
    rx_d <= b;
    for (i = 0; i < 500; i++) begin
      @(posedge core_clk);
      if (rx_r === 1'b1) break;
    end
    if (i == 500) check("host take", 8'h01, 8'h00);
    rx_v <= 1'b0;
  endtask
  // Independent bit-serial reference, msb first
  function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int k = 7; k >= 0; k--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ b[k]) ? svc_pkg::CRC_POLY : 16'h0000);
    end
    return r;
  endfunction
  // Host line is always ready, so each reply stands one cycle
  task automatic rx(input string nm, input logic [7:0] exp);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge core_clk);
      if (tx_v === 1'b1) break;
    end
    check(nm, exp, (i < 2000) ? tx_d : ~exp);
  endtask
  task automatic t_reset();
    check("flags", 8'h00, {5'h00, ap, crc, mk});
    check("mode", {6'h00, svc_pkg::M_STOP}, {6'h00, mode});
    check("reg0", svc_pkg::WDOG_RST, regs[0]);
  endtask
  task automatic t_regs();
    send(svc_pkg::OP_REG_WR | 8'h03);
    send(8'ha5);
    send(svc_pkg::OP_REG_RD | 8'h03);
    rx("reg read", 8'ha5);
    check("reg3", 8'ha5, regs[3]);
  endtask
  task automatic t_exit();
    send(svc_pkg::OP_EXIT_STOP);
    repeat (3) @(posedge core_clk);
    check("mode sync", {6'h00, svc_pkg::M_SYNC}, {6'h00, mode});
    sync_d <= 1'b1;
    @(posedge core_clk);
    sync_d <= 1'b0;
    rx("ready ack", svc_pkg::IND_READY);
    check("mode normal", {6'h00, svc_pkg::M_NORMAL}, {6'h00, mode});
  endtask
  // Offset set before begin must be cleared, index 1 overwritten
  task automatic frame(input logic [7:0] ck);
    logic [7:0] s [9];
    s = '{svc_pkg::OP_OFFSET | 8'h01, svc_pkg::OP_BEGIN, 8'hc3, svc_pkg::OP_CONT | 8'h01,
          8'h11, svc_pkg::OP_CONT | 8'h01, 8'h22, svc_pkg::OP_FINISH | 8'h02, ck};
    foreach (s[i]) send(s[i]);
  endtask
  task automatic t_frame();
    re <= 1'b1;
    ce <= 1'b1;
    te <= 1'b1;
    frame(8'h00);
    rx("bad sum", svc_pkg::IND_STATE_RE);
    frame(8'h1e);
    rx("echo ctrl", 8'hc3);
    rx("echo data", 8'h22);
    rx("echo sum", 8'h1e);
    rx("frame state", 8'hab);
    rx("confirm", 8'h0b);
    re <= 1'b0;
    ce <= 1'b0;
    te <= 1'b0;
  endtask
  // All features on: 0xcb doubled, CRC over sent bytes, marker end
  task automatic t_marker();
    logic [15:0] c;
    c = crc_ref(crc_ref(svc_pkg::CRC_INIT, 8'hcb), 8'h34);
    send(svc_pkg::OP_BEGIN);
    send(8'hcb);
    send(svc_pkg::OP_FINISH | 8'h01);
    send(8'h34);
    rx("echo marker", 8'hcb);
    rx("echo twice", 8'hcb);
    rx("echo sum2", 8'h34);
    rx("crc high", c[15:8]);
    rx("crc low", c[7:0]);
    rx("frame end", svc_pkg::IND_FRAME_END);
    rx("state clean", 8'h03);
    rx("confirm2", 8'h0b);
  endtask
  task automatic t_config();
    busy <= 1'b1;
    aa <= 1'b1;
    send(svc_pkg::OP_CONFIG);
    rx("status", 8'hc1);
    idle <= 1'b0;
    send(svc_pkg::OP_CONFIG | 8'h07);
    repeat (10) @(posedge core_clk);
    check("flags held", 8'h00, {5'h00, ap, crc, mk});
    idle <= 1'b1;
    rx("cfg ind", 8'hf9);
    check("flags on", 8'h07, {5'h00, ap, crc, mk});
    send(svc_pkg::OP_CONFIG);
    rx("status kept", 8'hf9);
    check("flags kept", 8'h07, {5'h00, ap, crc, mk});
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    {rx_v, rx_d, sync_d, busy, aa, re, ce, te} = '0;
    tx_rdy = 1'b1;
    idle = 1'b1;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_regs();
    t_exit();
    t_frame();
    t_config();
    t_marker();
    test_done();
  end
  // Whole run needs a few hundred cycles
  initial begin
    #400000;
    n_mismatch++;
    test_done();
  end
endmodule
